// ==== logic/lfs_pkg.sv ====
package lfs_pkg;

    localparam int CLK_MHZ = 250;
    localparam int CLK_HZ = CLK_MHZ * 1_000_000;

    // Supply must stay low this long before the device drops out
    localparam int UV_FALL_US = 50;
    localparam logic [15:0] UV_FALL_CYC = 16'(UV_FALL_US * CLK_MHZ);
    // Dimming input low time that forces shutdown, 32,750 cycles
    localparam logic [15:0] SHDN_LOW_CYC = 16'h7FEE;

    // Triangle dither of the boost frequency, in per mille of nominal
    localparam int DITHER_RATE_HZ = 12_500;
    localparam int DITHER_HALF_CYC = CLK_HZ / (2 * DITHER_RATE_HZ);
    localparam logic [10:0] DITHER_MIN_PM = 11'h3B6;
    localparam logic [10:0] DITHER_MAX_PM = 11'h41A;
    localparam int DITHER_SPAN = int'(DITHER_MAX_PM - DITHER_MIN_PM);
    localparam logic [7:0] DITHER_STEP_CYC =
        8'(DITHER_HALF_CYC / DITHER_SPAN);

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h8;
    localparam logic [3:0] ADDR_STATE = 4'hC;

    localparam int CTRL_RESCAN_BIT = 0;

    localparam int EV_LATCH = 0;
    localparam int EV_SHDN = 1;
    localparam int EV_UVLO = 2;
    localparam int EV_OPEN = 3;
    localparam int EV_FREQ_SET = 4;
    localparam int EV_CUR_SET = 5;
    localparam int EV_SHORT = 6;
    localparam int EV_OVP = 7;

    localparam int STF_STATE = 0;
    localparam int STF_MASK = 4;
    localparam int STF_RAISE = 8;
    localparam int STF_FAULT = 9;
    localparam int STF_PM = 16;

    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [3:0] SINK_MASK_RST = 4'hF;

    typedef enum logic [2:0] {
        ST_UVLO = 3'b000,
        ST_SHDN = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b011,
        ST_LATCH = 3'b100
    } lfs_state_t;

    typedef struct packed {
        logic dim;
        logic vin_rise_ok;
        logic vin_below_fall;
        logic primary_switch_current_limit;
        logic secondary_switch_current_limit;
        logic input_sense_node_oc;
        logic boost_switch_node_ovp;
        logic out_ovp;
        logic led_current_set_oc;
        logic frequency_set_oc;
        logic cycle_start;
        logic [3:0] led_sink_short;
        logic [3:0] led_in_reg;
    } lfs_pins_t;

    typedef struct packed {
        lfs_pins_t s1;
        lfs_pins_t s2;
        lfs_pins_t s3;
        lfs_pins_t held;
    } lfs_sync_t;

    typedef struct packed {
        lfs_state_t state;
        logic [15:0] uv_cnt;
        logic [15:0] low_cnt;
        logic [7:0] dith_cnt;
        logic [10:0] dith_pm;
        logic dith_up;
        logic [3:0] sink_mask;
        logic raise;
        logic trunc;
        logic softstart;
        logic boost_en;
        logic disc_en;
        logic bias_en;
        logic [3:0] sinks;
        logic fault_o;
        logic fault_oe;
        logic [7:0] status;
        logic [7:0] mask;
        logic irq;
        logic ack;
        logic waitreq;
        logic [31:0] rdata;
    } lfs_core_t;

endpackage : lfs_pkg

// ==== logic/lfs_sync.sv ====
module lfs_sync
    import lfs_pkg::*;
(
    input wire logic i_clk, // Switching clock
    input wire logic i_rst_b, // Synchronous reset, active low
    input wire lfs_pins_t i_pins, // Raw comparator and pin levels
    output lfs_pins_t o_pins // Filtered levels
);

    lfs_sync_t q;
    lfs_sync_t d;

    always_comb
    begin
        d = q;
        d.s1 = i_pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // A bit moves only once the last two stages agree
        d.held = (q.s3 & ~(q.s2 ^ q.s3)) | (q.held & (q.s2 ^ q.s3));
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_pins = q.held;

endmodule : lfs_sync

// ==== logic/lfs_supervisor.sv ====
// Overview of operation
// - Enable on rising supply; disable after 50us low
// - Long dimming low enters shutdown, clears faults
// - Shutdown keeps sinks off until dimming high
// - Shutdown turns off bias and disconnect gate
// - Boost frequency dithered between 0.95 and 1.05
// - Dither is a 12.5 kHz triangle
// - Primary current limit truncates one on-time only
// - Secondary current limit latches off, flags fault
// - Input sense overcurrent latches off, flags fault
// - Switch node overvoltage latches off, flags fault
// - Long dimming low releases a latched fault
// - Shorted sink holds soft-start, disconnect on
// - Open sink found via overvoltage, string dropped
// - Current-set overcurrent stops boost and sinks
// - Frequency-set overcurrent stops all but bias, flags fault
// - Output overvoltage pauses switching only
// - Fault flag pulls the open-drain pin low
// - Undervoltage clears latched faults, all off but bias
//
// The Avalon-MM register port and the register offsets were left to the implementer.
module lfs_supervisor
    import lfs_pkg::*;
#(
    parameter logic [15:0] P_UV_FALL_CYC = UV_FALL_CYC, // Drop-out delay
    parameter logic [15:0] P_SHDN_LOW_CYC = SHDN_LOW_CYC // Shutdown delay
)
(
    input wire logic I_CLK, // Switching clock, 250 MHz
    input wire logic I_RST_B, // Synchronous reset, active low
    input wire lfs_pins_t I_PINS, // Comparator and pin levels
    input wire logic [3:0] I_AVS_ADDRESS, // Byte address
    input wire logic I_AVS_READ, // Read request
    input wire logic I_AVS_WRITE, // Write request
    input wire logic [31:0] I_AVS_WRITEDATA, // Write data
    input wire logic [3:0] I_AVS_BYTEENABLE, // Byte lanes
    output logic [31:0] O_AVS_READDATA, // Read data
    output logic O_AVS_WAITREQUEST, // Stall, high until answer
    output logic O_BOOST_EN, // Boost may switch
    output logic O_TRUNC, // End present on-time
    output logic O_SOFTSTART, // Start soft-start ramp
    output logic O_RAISE_VOUT, // Raise output to find open sink
    output logic O_DISC_EN, // Disconnect switch gate drive
    output logic O_BIAS_EN, // Internal bias regulator
    output logic [3:0] O_SINK_EN, // Current sink enables
    output logic O_FAULT_O, // Fault pin level when driven
    output logic O_FAULT_OE, // Fault pin pulled low
    output logic [10:0] O_FREQ_PERMIL, // Frequency in per mille
    output logic O_IRQ // Interrupt, level
);

    localparam lfs_core_t CORE_RST = '{
        state: ST_UVLO,
        dith_pm: DITHER_MIN_PM,
        dith_up: 1'b1,
        sink_mask: SINK_MASK_RST,
        bias_en: 1'b1,
        status: STATUS_RST,
        mask: MASK_RST,
        waitreq: 1'b1,
        default: '0
    };

    lfs_pins_t pin;
    lfs_core_t q;
    lfs_core_t d;
    logic latch_trip;
    logic uv_off;
    logic shdn_trip;
    logic quiet;

    function automatic logic [3:0] reg_sel(input logic [3:0] addr);
        reg_sel = 4'h0;
        case (addr)
            ADDR_CTRL: reg_sel = 4'h1;
            ADDR_STATUS: reg_sel = 4'h2;
            ADDR_MASK: reg_sel = 4'h4;
            ADDR_STATE: reg_sel = 4'h8;
            default: reg_sel = 4'h0;
        endcase
    endfunction : reg_sel

    lfs_sync u_sync (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_pins(I_PINS),
        .o_pins(pin)
    );

    assign latch_trip = pin.secondary_switch_current_limit
        | pin.input_sense_node_oc
        | pin.boost_switch_node_ovp;
    assign uv_off = q.uv_cnt >= P_UV_FALL_CYC;
    assign shdn_trip = q.low_cnt >= P_SHDN_LOW_CYC;
    assign quiet = !latch_trip && !uv_off && !shdn_trip
        && !pin.frequency_set_oc;

    always_comb
    begin
        logic [3:0] sel;
        logic [7:0] ev;
        logic [7:0] w1c;
        logic wr_ok;
        logic live;
        logic run;
        logic hold;
        sel = reg_sel(I_AVS_ADDRESS);
        ev = 8'h00;
        w1c = 8'h00;
        wr_ok = q.ack && I_AVS_WRITE && I_AVS_BYTEENABLE[0];
        live = (q.state != ST_UVLO) && (q.state != ST_SHDN);
        run = 1'b0;
        hold = 1'b0;
        d = q;

        // Glitch filter: only a continuous low supply counts
        if (!pin.vin_below_fall)
        begin
            d.uv_cnt = 16'h0000;
        end
        else if (q.uv_cnt < P_UV_FALL_CYC)
        begin
            d.uv_cnt = q.uv_cnt + 16'h0001;
        end

        if (pin.dim)
        begin
            d.low_cnt = 16'h0000;
        end
        else if (q.low_cnt < P_SHDN_LOW_CYC)
        begin
            d.low_cnt = q.low_cnt + 16'h0001;
        end

        d.softstart = 1'b0;
        if (q.state != ST_UVLO && uv_off)
        begin
            d.state = ST_UVLO;
            ev[EV_UVLO] = 1'b1;
        end
        else if (live && shdn_trip)
        begin
            d.state = ST_SHDN;
            ev[EV_SHDN] = 1'b1;
        end
        else
        begin
            unique case (q.state)
                ST_UVLO:
                begin
                    if (pin.vin_rise_ok)
                    begin
                        d.state = ST_HOLD;
                    end
                end
                ST_SHDN:
                begin
                    if (pin.dim)
                    begin
                        d.state = ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (latch_trip)
                    begin
                        d.state = ST_LATCH;
                    end
                    else if (!pin.frequency_set_oc
                             && pin.led_sink_short == 4'h0)
                    begin
                        d.state = ST_RUN;
                        d.softstart = 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (latch_trip)
                    begin
                        d.state = ST_LATCH;
                    end
                    else if (pin.frequency_set_oc)
                    begin
                        d.state = ST_HOLD;
                    end
                end
                ST_LATCH:
                begin
                    d.state = ST_LATCH;
                end
                default:
                begin
                    d.state = ST_UVLO;
                end
            endcase
        end

        if (d.state == ST_LATCH && q.state != ST_LATCH)
        begin
            ev[EV_LATCH] = 1'b1;
        end
        ev[EV_FREQ_SET] = live && pin.frequency_set_oc;
        ev[EV_CUR_SET] = q.state == ST_RUN && pin.led_current_set_oc;
        ev[EV_SHORT] = q.state == ST_HOLD && pin.led_sink_short != 4'h0;
        ev[EV_OVP] = q.state == ST_RUN && pin.out_ovp;

        // Open sink search: raise output, drop strings not regulating
        if (q.state != ST_RUN)
        begin
            d.raise = 1'b0;
        end
        else if (pin.dim)
        begin
            if (q.raise && pin.out_ovp)
            begin
                d.sink_mask = q.sink_mask & pin.led_in_reg;
                d.raise = 1'b0;
                ev[EV_OPEN] = 1'b1;
            end
            else if ((q.sinks & ~pin.led_in_reg) != 4'h0)
            begin
                d.raise = 1'b1;
            end
        end

        if (wr_ok && sel[0] && I_AVS_WRITEDATA[CTRL_RESCAN_BIT])
        begin
            d.sink_mask = SINK_MASK_RST;
        end
        if (d.state == ST_SHDN || d.state == ST_UVLO)
        begin
            d.sink_mask = SINK_MASK_RST;
            d.raise = 1'b0;
        end

        // Truncation lasts only to the next cycle start
        d.trunc = (q.state == ST_RUN)
            && (pin.primary_switch_current_limit
                || (q.trunc && !pin.cycle_start));

        run = d.state == ST_RUN;
        hold = d.state == ST_HOLD;
        d.bias_en = d.state != ST_SHDN;
        d.disc_en = run || (hold && !pin.frequency_set_oc);
        d.boost_en = run && !pin.led_current_set_oc
            && !pin.out_ovp;
        d.sinks = (run && !pin.led_current_set_oc && pin.dim)
            ? d.sink_mask : 4'h0;
        d.fault_o = 1'b0;
        d.fault_oe = (d.state == ST_LATCH)
            || ((run || hold) && pin.frequency_set_oc);

        // Dither runs free of the enable state
        if (q.dith_cnt == DITHER_STEP_CYC - 8'h01)
        begin
            d.dith_cnt = 8'h00;
            d.dith_pm = q.dith_up ? q.dith_pm + 11'h001
                                  : q.dith_pm - 11'h001;
            if (d.dith_pm == DITHER_MAX_PM)
            begin
                d.dith_up = 1'b0;
            end
            else if (d.dith_pm == DITHER_MIN_PM)
            begin
                d.dith_up = 1'b1;
            end
        end
        else
        begin
            d.dith_cnt = q.dith_cnt + 8'h01;
        end

        // One wait state; write lands when waitrequest is seen low
        if (q.ack)
        begin
            d.ack = 1'b0;
            d.waitreq = 1'b1;
        end
        else if (I_AVS_READ || I_AVS_WRITE)
        begin
            d.ack = 1'b1;
            d.waitreq = 1'b0;
            d.rdata = 32'h0000_0000;
            if (sel[1])
            begin
                d.rdata[7:0] = q.status;
            end
            if (sel[2])
            begin
                d.rdata[7:0] = q.mask;
            end
            if (sel[3])
            begin
                d.rdata[STF_STATE +: 3] = q.state;
                d.rdata[STF_MASK +: 4] = q.sink_mask;
                d.rdata[STF_RAISE] = q.raise;
                d.rdata[STF_FAULT] = q.fault_oe;
                d.rdata[STF_PM +: 11] = q.dith_pm;
            end
        end
        if (wr_ok && sel[1])
        begin
            w1c = I_AVS_WRITEDATA[7:0];
        end
        if (wr_ok && sel[2])
        begin
            d.mask = I_AVS_WRITEDATA[7:0];
        end
        // New events win over a clear in the same cycle
        d.status = (q.status & ~w1c) | ev;
        d.irq = |(d.status & d.mask);
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_B)
        begin
            q <= CORE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign O_AVS_READDATA = q.rdata;
    assign O_AVS_WAITREQUEST = q.waitreq;
    assign O_BOOST_EN = q.boost_en;
    assign O_TRUNC = q.trunc;
    assign O_SOFTSTART = q.softstart;
    assign O_RAISE_VOUT = q.raise;
    assign O_DISC_EN = q.disc_en;
    assign O_BIAS_EN = q.bias_en;
    assign O_SINK_EN = q.sinks;
    assign O_FAULT_O = q.fault_o;
    assign O_FAULT_OE = q.fault_oe;
    assign O_FREQ_PERMIL = q.dith_pm;
    assign O_IRQ = q.irq;

    uv_lockout_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state != ST_UVLO && uv_off |=>
        q.state == ST_UVLO && !O_DISC_EN && !O_BOOST_EN
    ) else $error("supply drop-out did not disable");

    uv_clear_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_LATCH && uv_off |=> !O_FAULT_OE && O_SINK_EN == 4'h0
    ) else $error("undervoltage did not clear latch");

    shdn_entry_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state inside {ST_HOLD, ST_RUN, ST_LATCH} && !uv_off && shdn_trip
        |=> q.state == ST_SHDN && q.sink_mask == SINK_MASK_RST
    ) else $error("long low did not shut down");

    shdn_sinks_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_SHDN && !pin.dim && !uv_off |=>
        q.state == ST_SHDN && O_SINK_EN == 4'h0
    ) else $error("shutdown left early or sinks on");

    shdn_bias_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_SHDN |-> !O_BIAS_EN && !O_DISC_EN
    ) else $error("bias or disconnect on in shutdown");

    dither_band_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        O_FREQ_PERMIL >= DITHER_MIN_PM && O_FREQ_PERMIL <= DITHER_MAX_PM
    ) else $error("dither out of band");

    dither_step_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.dith_cnt != DITHER_STEP_CYC - 8'h01 |=> $stable(O_FREQ_PERMIL)
    ) else $error("dither moved between steps");

    trunc_cut_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_RUN && pin.primary_switch_current_limit && quiet
        |=> O_TRUNC && O_DISC_EN && !O_FAULT_OE
    ) else $error("on-time not truncated");

    latch_off_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state inside {ST_HOLD, ST_RUN} && latch_trip && !uv_off
        && !shdn_trip |=> q.state == ST_LATCH && O_FAULT_OE
        && !O_DISC_EN && !O_BOOST_EN && O_SINK_EN == 4'h0
    ) else $error("protection fault did not latch");

    latch_hold_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_LATCH && !uv_off && !shdn_trip |=> q.state == ST_LATCH
    ) else $error("latch released without long low");

    short_hold_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_HOLD && pin.led_sink_short != 4'h0 && quiet
        |=> q.state == ST_HOLD && O_DISC_EN && !O_BOOST_EN && !O_FAULT_OE
    ) else $error("soft-start not held on short");

    open_drop_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_RUN && q.raise && pin.out_ovp && pin.dim && quiet
        |=> !q.raise && (q.sink_mask & ~$past(pin.led_in_reg)) == 4'h0
    ) else $error("open string not dropped");

    cur_set_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_RUN && pin.led_current_set_oc && quiet |=>
        !O_BOOST_EN && O_SINK_EN == 4'h0 && O_DISC_EN && !O_FAULT_OE
    ) else $error("current-set fault response wrong");

    freq_set_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_RUN && pin.frequency_set_oc && !latch_trip
        && !uv_off && !shdn_trip |=> q.state == ST_HOLD
        && O_FAULT_OE && !O_DISC_EN && !O_BOOST_EN
    ) else $error("frequency-set fault response wrong");

    out_ovp_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        q.state == ST_RUN && pin.out_ovp && quiet |=>
        !O_BOOST_EN && O_DISC_EN && !O_FAULT_OE
    ) else $error("overvoltage did not pause switching");

    fault_pin_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        O_FAULT_OE |-> !O_FAULT_O
    ) else $error("fault pin driven high");

    low_restart_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_B)
        pin.dim |=> q.low_cnt == 16'h0000
    ) else $error("low counter not restarted");

endmodule : lfs_supervisor

// ==== test/lfs_host.sv ====
module lfs_host
(
    input wire logic i_clk, // Switching clock
    input wire logic i_fault_oe, // Flag pin pulled low
    output logic o_dim, // Dimming input level
    output logic o_fault_n // Flag pin level seen by host
);
    timeunit 1ns;
    timeprecision 1ps;

    logic dim_q = 1'b1;

    assign o_dim = dim_q;
    // Board pull-up sets the level whenever the pin is released
    assign o_fault_n = i_fault_oe ? 1'b0 : 1'b1;

    task set_dim(input logic lvl);
        @(posedge i_clk);
        dim_q <= lvl;
    endtask : set_dim
endmodule : lfs_host

// ==== test/tb.sv ====
module tb
    import lfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    lfs_pins_t pv;
    lfs_pins_t pins_in;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic [31:0] v;
    logic wait_r, boost, trunc, ss, raise, disc, bias, fo, foe, irq;
    logic dim, fault_n;
    logic [3:0] sinks;
    logic [10:0] fpm;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int ss_cnt = 0;
    int n;

    always #2 clk = ~clk;

    always_comb
    begin
        pins_in = pv;
        pins_in.dim = dim;
    end

    lfs_supervisor #(.P_UV_FALL_CYC(16'h0014), .P_SHDN_LOW_CYC(16'h0028))
        i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_PINS(pins_in),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_r),
        .O_BOOST_EN(boost), .O_TRUNC(trunc), .O_SOFTSTART(ss),
        .O_RAISE_VOUT(raise), .O_DISC_EN(disc), .O_BIAS_EN(bias),
        .O_SINK_EN(sinks), .O_FAULT_O(fo), .O_FAULT_OE(foe),
        .O_FREQ_PERMIL(fpm), .O_IRQ(irq));

    lfs_host i_host (.i_clk(clk), .i_fault_oe(foe), .o_dim(dim),
        .o_fault_n(fault_n));

    task tick(input int cnt);
        repeat (cnt) @(posedge clk);
    endtask : tick

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until the edge that samples waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wait_r !== 1'b0)
        begin
            @(posedge clk);
        end
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task outs(input logic [6:0] e);
        chk(32'({boost, disc, sinks, foe}), 32'(e));
    endtask : outs

    task st(input logic [2:0] e);
        bus(1'b0, ADDR_STATE, 32'h0);
        chk(32'(v[2:0]), 32'(e));
    endtask : st

    task wait_f(input logic [10:0] f);
        n = 0;
        while (fpm !== f && n < 20000)
        begin
            tick(1);
            n++;
        end
    endtask : wait_f

    task results;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        cyc++;
        if (ss === 1'b1)
            ss_cnt++;
        // Dither must never leave the band
        if (rst_b && (fpm < DITHER_MIN_PM || fpm > DITHER_MAX_PM))
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, fpm, DITHER_MIN_PM);
        end
        if (cyc == 60000)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, cyc, 0);
            results();
        end
    end

    initial
    begin
        pv = '0;
        pv.led_in_reg = 4'hF;
        tick(16);
        rst_b <= 1'b1;
        tick(2);
        outs(7'h00);
        chk(32'(fpm), 32'h3B6);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(v, 32'h0);
        // Write without the low byte lane must be ignored
        be <= 4'hE;
        bus(1'b1, ADDR_MASK, 32'hFF);
        be <= 4'hF;
        bus(1'b0, ADDR_MASK, 32'h0);
        chk(v, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk(v, 32'h0);
        st(3'h0);
        pv.led_sink_short <= 4'h2;
        pv.vin_rise_ok <= 1'b1;
        tick(10);
        st(3'h2);
        outs(7'h20);
        pv.led_sink_short <= 4'h0;
        tick(10);
        st(3'h3);
        outs(7'h7E);
        chk(32'(ss_cnt), 32'h1);
        $display("Test startup done");
        wait_f(11'h41A);
        wait_f(11'h3B6);
        chk(32'(n >= 9990 && n <= 10010), 32'h1);
        $display("Test dither done");
        pv.out_ovp <= 1'b1;
        tick(8);
        outs(7'h3E);
        pv.out_ovp <= 1'b0;
        tick(8);
        outs(7'h7E);
        pv.led_current_set_oc <= 1'b1;
        tick(8);
        outs(7'h20);
        pv.led_current_set_oc <= 1'b0;
        tick(8);
        outs(7'h7E);
        pv.primary_switch_current_limit <= 1'b1;
        tick(8);
        chk(32'(trunc), 32'h1);
        outs(7'h7E);
        pv.primary_switch_current_limit <= 1'b0;
        pv.cycle_start <= 1'b1;
        tick(8);
        pv.cycle_start <= 1'b0;
        chk(32'(trunc), 32'h0);
        pv.led_in_reg <= 4'hE;
        tick(8);
        chk(32'(raise), 32'h1);
        pv.out_ovp <= 1'b1;
        tick(8);
        pv.out_ovp <= 1'b0;
        pv.led_in_reg <= 4'hF;
        tick(8);
        outs(7'h7C);
        chk(32'(raise), 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h1);
        tick(4);
        outs(7'h7E);
        pv.frequency_set_oc <= 1'b1;
        tick(8);
        outs(7'h01);
        pv.frequency_set_oc <= 1'b0;
        tick(10);
        outs(7'h7E);
        chk(32'(ss_cnt), 32'h2);
        $display("Test auto-restart faults done");
        bus(1'b1, ADDR_MASK, 32'h1);
        // Bits 14..12 of the pin struct are the three latching causes
        for (int k = 0; k < 3; k++)
        begin
            pv[14 - k] <= 1'b1;
            tick(8);
            pv[14 - k] <= 1'b0;
            tick(8);
            outs(7'h01);
            chk(32'(fault_n), 32'h0);
            chk(32'(fo), 32'h0);
            chk(32'(irq), 32'h1);
            i_host.set_dim(1'b0);
            tick(30);
            i_host.set_dim(1'b1);
            tick(8);
            i_host.set_dim(1'b0);
            tick(30);
            st(3'h4);
            tick(20);
            st(3'h1);
            outs(7'h00);
            chk(32'(bias), 32'h0);
            chk(32'(fault_n), 32'h1);
            i_host.set_dim(1'b1);
            tick(10);
            st(3'h3);
            outs(7'h7E);
            chk(32'(bias), 32'h1);
            bus(1'b0, ADDR_STATUS, 32'h0);
            chk(32'(v[1:0]), 32'h3);
            bus(1'b1, ADDR_STATUS, 32'hFF);
            tick(2);
            chk(32'(irq), 32'h0);
        end
        $display("Test latched faults done");
        pv.vin_below_fall <= 1'b1;
        tick(12);
        pv.vin_below_fall <= 1'b0;
        tick(8);
        st(3'h3);
        pv.secondary_switch_current_limit <= 1'b1;
        tick(8);
        pv.secondary_switch_current_limit <= 1'b0;
        st(3'h4);
        pv.vin_rise_ok <= 1'b0;
        pv.vin_below_fall <= 1'b1;
        tick(30);
        st(3'h0);
        outs(7'h00);
        pv.vin_below_fall <= 1'b0;
        pv.vin_rise_ok <= 1'b1;
        tick(10);
        st(3'h3);
        outs(7'h7E);
        $display("Test undervoltage done");
        results();
    end
endmodule : tb
